// *** hw/decimal_edit_mark_unit.sv ***
// Operation
// - end on result full or pattern exhausted
// - marker gets address before first significant digit
// - zero digit stores fill until significance
// - significance start sets flag, stores nothing
// - positive sign clears significance, no byte
// - negative sign keeps significance set
// - ordinary first pattern byte becomes fill
// - special first pattern byte gives blank fill
// - trailing separator stores blank, flags zero field
// - unreached pattern and digits never examined
// - nonzero and significant sets negative flag, marker
// - sign in left nibble flags data fault
// - stored digit gets ascii or ebcdic zone
// - sign codes split into positive and negative
// - nonzero and not significant sets positive flag
`timescale 1ns/1ns
`default_nettype none

module decimal_edit_mark_unit (
	input  wire logic                   clk_sys,
	input  wire logic                   reset_n,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [7:0]             paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	output edit_mark_pkg::mem_req_s     mem_req,
	input  wire edit_mark_pkg::mem_rsp_s mem_rsp
);

	// ==========================================================
	// register bus
	edit_mark_pkg::cfg_s cfg_r;
	edit_mark_pkg::cfg_s cfg_nxt;
	logic [31:0]         prdata_r;
	logic [31:0]         prdata_nxt;
	logic                slverr_r;
	logic                slverr_nxt;
	logic                start;
	logic                busy;

	edit_mark_pkg::ctx_s ctx_r;
	edit_mark_pkg::ctx_s ctx_nxt;

	assign busy    = ctx_r.st != edit_mark_pkg::st_idle;
	assign pready  = 1'b1;
	assign prdata  = prdata_r;
	assign pslverr = slverr_r;
	assign mem_req = ctx_r.req;

	// read data is prepared in the setup cycle so the access phase needs no wait
	always_comb begin
		cfg_nxt    = cfg_r;
		prdata_nxt = prdata_r;
		slverr_nxt = slverr_r;
		start      = 1'b0;
		if (psel && !penable) begin
			prdata_nxt = '0;
			slverr_nxt = 1'b0;
			case (paddr)
				edit_mark_pkg::off_ctrl: begin
					prdata_nxt[edit_mark_pkg::ctrl_ascii] = cfg_r.ascii;
				end
				edit_mark_pkg::off_status: begin
					prdata_nxt[edit_mark_pkg::sts_busy] = busy;
					prdata_nxt[edit_mark_pkg::sts_done] = ctx_r.done;
				end
				edit_mark_pkg::off_pat_base: begin
					prdata_nxt = cfg_r.pat_base;
				end
				edit_mark_pkg::off_pat_len: begin
					prdata_nxt = 32'(cfg_r.pat_len);
				end
				edit_mark_pkg::off_src_base: begin
					prdata_nxt = cfg_r.src_base;
				end
				edit_mark_pkg::off_res_base: begin
					prdata_nxt = cfg_r.res_base;
				end
				edit_mark_pkg::off_res_len: begin
					prdata_nxt = 32'(cfg_r.res_len);
				end
				edit_mark_pkg::off_flags: begin
					prdata_nxt[edit_mark_pkg::flag_fault - edit_mark_pkg::flag_base] =
						ctx_r.fl_fault;
					prdata_nxt[edit_mark_pkg::flag_zero - edit_mark_pkg::flag_base] =
						ctx_r.fl_zero;
					prdata_nxt[edit_mark_pkg::flag_neg - edit_mark_pkg::flag_base] =
						ctx_r.fl_neg;
					prdata_nxt[edit_mark_pkg::flag_pos - edit_mark_pkg::flag_base] =
						ctx_r.fl_pos;
				end
				edit_mark_pkg::off_mark_lo: begin
					prdata_nxt = ctx_r.gword[31:0];
				end
				edit_mark_pkg::off_mark_hi: begin
					// upper 16 bits of the marker word are always zero
					prdata_nxt = 32'(ctx_r.gword >> edit_mark_pkg::word_w);
				end
				default: begin
					slverr_nxt = 1'b1;
				end
			endcase
		end
		// configuration is frozen while an edit runs
		if (psel && penable && pwrite && !slverr_r && !busy) begin
			case (paddr)
				edit_mark_pkg::off_ctrl: begin
					cfg_nxt.ascii = pwdata[edit_mark_pkg::ctrl_ascii];
					start         = pwdata[edit_mark_pkg::ctrl_start];
				end
				edit_mark_pkg::off_pat_base: begin
					cfg_nxt.pat_base = pwdata;
				end
				edit_mark_pkg::off_pat_len: begin
					cfg_nxt.pat_len = pwdata[edit_mark_pkg::len_w-1:0];
				end
				edit_mark_pkg::off_src_base: begin
					cfg_nxt.src_base = pwdata;
				end
				edit_mark_pkg::off_res_base: begin
					cfg_nxt.res_base = pwdata;
				end
				edit_mark_pkg::off_res_len: begin
					cfg_nxt.res_len = pwdata[edit_mark_pkg::len_w-1:0];
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cfg_r    <= '0;
			prdata_r <= '0;
			slverr_r <= 1'b0;
		end else begin
			cfg_r    <= cfg_nxt;
			prdata_r <= prdata_nxt;
			slverr_r <= slverr_nxt;
		end
	end

	// ==========================================================
	// pattern decode
	logic [1:0] xx;
	logic [3:0] zone;
	logic [7:0] blank;
	logic       is_dig;
	logic       is_sig;
	logic       is_sep;
	logic       is_ign;
	logic       is_spec;

	localparam int unsigned addr_w_c = edit_mark_pkg::addr_w;

	logic [addr_w_c-1:0] res_addr;

	assign xx    = cfg_r.ascii ? edit_mark_pkg::xx_ascii : edit_mark_pkg::xx_ebcdic;
	assign zone  = cfg_r.ascii ? edit_mark_pkg::zone_ascii
		: edit_mark_pkg::zone_ebcdic;
	assign blank = cfg_r.ascii ? edit_mark_pkg::blank_ascii : edit_mark_pkg::blank_ebcdic;
	assign is_dig  = ctx_r.pat == {xx, edit_mark_pkg::pc_digit};
	assign is_sig  = ctx_r.pat == {xx, edit_mark_pkg::pc_sig};
	assign is_sep  = ctx_r.pat == {xx, edit_mark_pkg::pc_sep};
	assign is_ign  = ctx_r.pat == {xx, edit_mark_pkg::pc_ign};
	assign is_spec = is_dig || is_sig || is_sep || is_ign;
	assign res_addr = addr_w_c'(cfg_r.res_base) + addr_w_c'(ctx_r.ri);

	// ==========================================================
	// edit sequencer
	logic       adv;
	logic       fin;
	logic       put;
	logic [7:0] put_b;
	logic [3:0] lo_nib;
	logic [3:0] hi_nib;

	assign hi_nib = mem_rsp.rdata[7:4];
	assign lo_nib = mem_rsp.rdata[3:0];

	always_comb begin
		ctx_nxt = ctx_r;
		adv     = 1'b0;
		fin     = 1'b0;
		put     = 1'b0;
		put_b   = '0;
		case (ctx_r.st)
			edit_mark_pkg::st_idle: begin
				if (start) begin
					ctx_nxt.pi       = '0;
					ctx_nxt.ri       = '0;
					ctx_nxt.sa       = addr_w_c'(cfg_r.src_base);
					ctx_nxt.first    = 1'b1;
					ctx_nxt.t        = 1'b0;
					ctx_nxt.nz       = 1'b0;
					ctx_nxt.sgn      = 1'b0;
					ctx_nxt.fault    = 1'b0;
					ctx_nxt.pend     = 1'b0;
					ctx_nxt.fill     = blank;
					ctx_nxt.done     = 1'b0;
					ctx_nxt.fl_fault = 1'b0;
					ctx_nxt.fl_zero  = 1'b0;
					ctx_nxt.fl_neg   = 1'b0;
					ctx_nxt.fl_pos   = 1'b0;
					adv              = 1'b1;
				end
			end
			edit_mark_pkg::st_pat: begin
				if (mem_rsp.ready) begin
					ctx_nxt.req.valid = 1'b0;
					ctx_nxt.pat       = mem_rsp.rdata;
					ctx_nxt.pi        = ctx_r.pi + 1'b1;
					ctx_nxt.st        = edit_mark_pkg::st_exec;
				end
			end
			edit_mark_pkg::st_exec: begin
				ctx_nxt.first = 1'b0;
				if (ctx_r.first && !is_spec) begin
					ctx_nxt.fill = ctx_r.pat;
					adv          = 1'b1;
				end else if (is_sig) begin
					ctx_nxt.t = 1'b1;
					adv       = 1'b1;
				end else if (is_sep) begin
					ctx_nxt.t   = 1'b0;
					ctx_nxt.nz  = 1'b0;
					ctx_nxt.sgn = 1'b0;
					if (ctx_r.pi == cfg_r.pat_len) begin
						put   = 1'b1;
						put_b = blank;
					end else begin
						adv = 1'b1;
					end
				end else if (is_dig || is_ign) begin
					if (ctx_r.sgn) begin
						// a second numeric field before any separator
						ctx_nxt.fault = 1'b1;
						fin           = 1'b1;
					end else if (ctx_r.pend) begin
						ctx_nxt.dg   = ctx_r.rnib;
						ctx_nxt.pend = 1'b0;
						ctx_nxt.scp  = 1'b0;
						ctx_nxt.st   = edit_mark_pkg::st_dig;
					end else begin
						ctx_nxt.req = '{1'b1, 1'b0, ctx_r.sa, 8'h00};
						ctx_nxt.st  = edit_mark_pkg::st_src;
					end
				end else begin
					put   = 1'b1;
					put_b = ctx_r.t ? ctx_r.pat : ctx_r.fill;
				end
			end
			edit_mark_pkg::st_src: begin
				if (mem_rsp.ready) begin
					ctx_nxt.req.valid = 1'b0;
					ctx_nxt.sa        = ctx_r.sa + 1'b1;
					if (edit_mark_pkg::is_sign(hi_nib)) begin
						ctx_nxt.fault = 1'b1;
						fin           = 1'b1;
					end else begin
						ctx_nxt.dg    = hi_nib;
						ctx_nxt.scp   = edit_mark_pkg::is_sign(lo_nib);
						ctx_nxt.scpos = edit_mark_pkg::is_pos(lo_nib);
						ctx_nxt.pend  = !edit_mark_pkg::is_sign(lo_nib);
						ctx_nxt.rnib  = lo_nib;
						ctx_nxt.st    = edit_mark_pkg::st_dig;
					end
				end
			end
			edit_mark_pkg::st_dig: begin
				if (is_dig) begin
					put = 1'b1;
					if (ctx_r.dg != '0) begin
						ctx_nxt.nz = 1'b1;
					end
					if (ctx_r.t || ctx_r.dg != '0) begin
						put_b = {zone, ctx_r.dg};
						if (!ctx_r.t) begin
							ctx_nxt.t    = 1'b1;
							ctx_nxt.mark = res_addr - addr_w_c'(1);
						end
					end else begin
						put_b = ctx_r.fill;
					end
				end else begin
					// ignored digit: a source digit is consumed, no byte
					adv = 1'b1;
				end
				// sign acts after its digit is examined
				if (ctx_r.scp) begin
					ctx_nxt.sgn = 1'b1;
					if (ctx_r.scpos) begin
						ctx_nxt.t = 1'b0;
					end
				end
			end
			edit_mark_pkg::st_wr: begin
				if (mem_rsp.ready) begin
					ctx_nxt.req.valid = 1'b0;
					ctx_nxt.ri        = ctx_r.ri + 1'b1;
					adv               = 1'b1;
				end
			end
			default: begin
				ctx_nxt.st = edit_mark_pkg::st_idle;
			end
		endcase
		if (put) begin
			ctx_nxt.req = '{1'b1, 1'b1, res_addr, put_b};
			ctx_nxt.st  = edit_mark_pkg::st_wr;
		end
		// nothing beyond either end is read or written
		if (adv) begin
			if (ctx_nxt.ri == cfg_r.res_len || ctx_nxt.pi == cfg_r.pat_len) begin
				fin = 1'b1;
			end else begin
				ctx_nxt.req = '{1'b1, 1'b0,
					addr_w_c'(cfg_r.pat_base) + addr_w_c'(ctx_nxt.pi), 8'h00};
				ctx_nxt.st  = edit_mark_pkg::st_pat;
			end
		end
		if (fin) begin
			ctx_nxt.st   = edit_mark_pkg::st_idle;
			ctx_nxt.done = 1'b1;
			if (ctx_nxt.fault) begin
				ctx_nxt.fl_fault = 1'b1;
			end else begin
				ctx_nxt.fl_zero = !ctx_nxt.nz;
				ctx_nxt.fl_neg  = ctx_nxt.nz && ctx_nxt.t;
				ctx_nxt.fl_pos  = ctx_nxt.nz && !ctx_nxt.t;
				if (ctx_nxt.nz && ctx_nxt.t) begin
					ctx_nxt.gword = ctx_nxt.mark;
				end
			end
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			ctx_r <= '0;
		end else begin
			ctx_r <= ctx_nxt;
		end
	end

endmodule : decimal_edit_mark_unit

`default_nettype wire

// *** shared/edit_mark_pkg.sv ***
package edit_mark_pkg;
	localparam int unsigned addr_w = 48;
	localparam int unsigned len_w  = 16;
	localparam int unsigned word_w = 32;

	// ==========================================================
	// register map
	localparam logic [7:0] off_ctrl     = 8'h00;
	localparam logic [7:0] off_status   = 8'h04;
	localparam logic [7:0] off_pat_base = 8'h08;
	localparam logic [7:0] off_pat_len  = 8'h0c;
	localparam logic [7:0] off_src_base = 8'h10;
	localparam logic [7:0] off_res_base = 8'h14;
	localparam logic [7:0] off_res_len  = 8'h18;
	localparam logic [7:0] off_flags    = 8'h1c;
	localparam logic [7:0] off_mark_lo  = 8'h20;
	localparam logic [7:0] off_mark_hi  = 8'h24;

	localparam int unsigned ctrl_start = 0;
	localparam int unsigned ctrl_ascii = 1;
	localparam int unsigned sts_busy   = 0;
	localparam int unsigned sts_done   = 1;

	// flag register holds data flag bits 63..32
	localparam int unsigned flag_base  = 32;
	localparam int unsigned flag_fault = 38;
	localparam int unsigned flag_zero  = 53;
	localparam int unsigned flag_neg   = 54;
	localparam int unsigned flag_pos   = 55;

	// ==========================================================
	// character codes
	localparam logic [5:0] pc_digit = 6'h20;
	localparam logic [5:0] pc_sig   = 6'h21;
	localparam logic [5:0] pc_sep   = 6'h22;
	localparam logic [5:0] pc_ign   = 6'h23;
	localparam logic [1:0] xx_ascii  = 2'h3;
	localparam logic [1:0] xx_ebcdic = 2'h0;
	localparam logic [3:0] zone_ascii  = 4'h3;
	localparam logic [3:0] zone_ebcdic = 4'hf;
	localparam logic [7:0] blank_ascii  = 8'h20;
	localparam logic [7:0] blank_ebcdic = 8'h40;
	localparam logic [3:0] sign_min = 4'ha;
	localparam logic [3:0] neg_b    = 4'hb;
	localparam logic [3:0] neg_d    = 4'hd;

	// ==========================================================
	// types
	typedef enum logic [2:0] {st_idle, st_pat, st_exec, st_src, st_dig, st_wr} state_e;

	typedef struct packed {
		logic              valid;
		logic              we;
		logic [addr_w-1:0] addr;
		logic [7:0]        wdata;
	} mem_req_s;

	typedef struct packed {
		logic       ready;
		logic [7:0] rdata;
	} mem_rsp_s;

	typedef struct packed {
		logic              ascii;
		logic [word_w-1:0] pat_base;
		logic [len_w-1:0]  pat_len;
		logic [word_w-1:0] src_base;
		logic [word_w-1:0] res_base;
		logic [len_w-1:0]  res_len;
	} cfg_s;

	typedef struct packed {
		state_e            st;
		mem_req_s          req;
		logic [len_w-1:0]  pi;
		logic [len_w-1:0]  ri;
		logic [addr_w-1:0] sa;
		logic              first;
		logic              t;
		logic              nz;
		logic              sgn;
		logic              fault;
		logic              pend;
		logic [3:0]        rnib;
		logic [3:0]        dg;
		logic              scp;
		logic              scpos;
		logic [7:0]        fill;
		logic [7:0]        pat;
		logic [addr_w-1:0] mark;
		logic [addr_w-1:0] gword;
		logic              done;
		logic              fl_fault;
		logic              fl_zero;
		logic              fl_neg;
		logic              fl_pos;
	} ctx_s;

	function automatic logic is_sign(input logic [3:0] nib);
		is_sign = nib >= sign_min;
	endfunction : is_sign

	function automatic logic is_pos(input logic [3:0] nib);
		is_pos = is_sign(nib) && nib != neg_b && nib != neg_d;
	endfunction : is_pos
endpackage : edit_mark_pkg

// *** tb/decimal_edit_mark_unit_properties.sv ***
`timescale 1ns/1ns
`default_nettype none

module edit_mark_checker (
	input wire logic                    clk_sys,
	input wire logic                    reset_n,
	input wire logic                    psel,
	input wire logic                    penable,
	input wire logic                    pwrite,
	input wire logic [7:0]              paddr,
	input wire logic [31:0]             pwdata,
	input wire logic [31:0]             prdata,
	input wire logic                    pready,
	input wire logic                    pslverr,
	input wire edit_mark_pkg::mem_req_s mem_req,
	input wire edit_mark_pkg::mem_rsp_s mem_rsp
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	// ==========================================================
	// shadow of the setup registers and of the result writes
	logic        op_r;
	logic        seen_r;
	logic [31:0] pb_r;
	logic [31:0] rb_r;
	logic [15:0] pl_r;
	logic [15:0] rl_r;
	logic [15:0] wc_r;
	logic [47:0] wa_r;
	wire acc = psel && penable && pready;
	wire rd = acc && !pwrite;
	// a start while busy is ignored, so op_r only clears on a done status
	wire start = acc && pwrite && paddr == 8'h00 && pwdata[0] && !op_r;
	wire wr_acc = mem_req.valid && mem_req.we && mem_rsp.ready;

	always_ff @(posedge clk_sys) begin
		if (acc && pwrite && !op_r) begin
			case (paddr)
				8'h08: pb_r <= pwdata;
				8'h0c: pl_r <= pwdata[15:0];
				8'h14: rb_r <= pwdata;
				8'h18: rl_r <= pwdata[15:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			op_r <= 1'b0;
			seen_r <= 1'b0;
			wc_r <= 16'h0;
			wa_r <= 48'h0;
		end else if (start) begin
			op_r <= 1'b1;
			seen_r <= 1'b0;
			wc_r <= 16'h0;
		end else begin
			if (rd && paddr == 8'h04 && prdata[1])
				op_r <= 1'b0;
			if (wr_acc) begin
				seen_r <= 1'b1;
				wc_r <= wc_r + 16'h1;
				wa_r <= mem_req.addr;
			end
		end
	end

	AST_REQ_HOLD: assert property (mem_req.valid && !mem_rsp.ready |=> $stable(mem_req))
		else $error("memory request changed while stalled");
	AST_REQ_DROP: assert property (mem_req.valid && !mem_req.we && mem_rsp.ready |=>
		!mem_req.valid)
		else $error("memory read not dropped after acceptance");
	AST_WR_NEXT: assert property (wr_acc |=> !(mem_req.valid && mem_req.we))
		else $error("result write not followed by a pattern read or the end");
	AST_FIRST_READ: assert property (start && pl_r != 0 && rl_r != 0 |=>
		mem_req.valid && !mem_req.we && mem_req.addr == {16'h0, pb_r})
		else $error("first pattern read missing");
	AST_WR_ADDR: assert property (wr_acc |->
		mem_req.addr == (seen_r ? wa_r + 48'h1 : {16'h0, rb_r}))
		else $error("result byte out of order");
	AST_WR_LIMIT: assert property (wr_acc |-> wc_r < rl_r)
		else $error("result written past its length");
	AST_MARK_HI: assert property (rd && paddr == 8'h24 |-> prdata[31:16] == 16'h0)
		else $error("marker upper bits not zero");
	AST_FLAG_ONE: assert property (rd && paddr == 8'h1c |-> $onehot0(prdata[23:21]))
		else $error("more than one status flag");
	AST_FAULT_ONLY: assert property (rd && paddr == 8'h1c && prdata[6] |->
		prdata[23:21] == 3'h0)
		else $error("fault with status flag");
endmodule : edit_mark_checker

bind decimal_edit_mark_unit edit_mark_checker i_chk (
	.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_rsp(mem_rsp)
);

`default_nettype wire

// *** tb/decimal_edit_mark_unit_tb.sv ***
`timescale 1ns/1ns
`default_nettype none

module decimal_edit_mark_unit_tb;
	typedef struct packed {
		logic [7:0]  addr;
		logic [32:0] exp;
		logic [32:0] mask;
	} note_s;
	logic                    clk_sys = 1'b0;
	logic                    reset_n = 1'b0;
	logic                    psel = 1'b0;
	logic                    penable = 1'b0;
	logic                    pwrite = 1'b0;
	logic                    stall = 1'b0;
	logic [7:0]              paddr = 8'h00;
	logic [31:0]             pwdata = 32'h0;
	logic [31:0]             prdata;
	logic [31:0]             rd_v;
	logic [31:0]             seed = 32'd72;
	logic                    pready;
	logic                    pslverr;
	edit_mark_pkg::mem_req_s mem_req;
	edit_mark_pkg::mem_rsp_s mem_rsp;
	note_s                   q[$];
	int                      n_errors = 0;
	int                      compares = 0;

	decimal_edit_mark_unit i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_rsp(mem_rsp));
	edit_mark_mem i_mem (.clk_sys(clk_sys), .stall(stall), .mem_req(mem_req), .mem_rsp(mem_rsp));

	initial forever #2 clk_sys = ~clk_sys;

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	// the memory stalls about one cycle in four
	always @(posedge clk_sys) stall <= (rnd() & 32'h3) == 32'h0;

	// ==========================================================
	// checking
	task automatic complete_run();
		$display("compares %0d errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : complete_run

	task automatic cmp_reg(input note_s n, input logic [32:0] got);
		compares++;
		if ((got & n.mask) !== n.exp) begin
			n_errors++;
			$display("ERROR reg %h expected %h seen %h", n.addr, n.exp, got & n.mask);
		end
	endtask : cmp_reg

	task automatic cmp_byte(input int a, input logic [7:0] e);
		compares++;
		if (i_mem.mem[a] !== e) begin
			n_errors++;
			$display("ERROR byte %h expected %h seen %h", a, e, i_mem.mem[a]);
		end
	endtask : cmp_byte

	always @(posedge clk_sys) begin
		if (psel && penable && pready && !pwrite)
			cmp_reg(q.pop_front(), {pslverr, prdata});
	end

	// ==========================================================
	// bus and operation tasks
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1) @(posedge clk_sys);
		rd_v = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask : apb

	task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [31:0] m = '1);
		q.push_back({a, e, {1'b1, m}});
		apb(1'b0, a, 32'h0);
	endtask : rd

	task automatic run(input logic asc, input logic [7:0] p[$], input logic [7:0] s[$],
			input int rlen);
		foreach (p[i]) i_mem.mem[256 + i] = p[i];
		foreach (s[i]) i_mem.mem[512 + i] = s[i];
		for (int i = 0; i < 16; i++) i_mem.mem[768 + i] = 8'hee;
		apb(1'b1, 8'h08, 32'h100);
		apb(1'b1, 8'h0c, 32'(p.size()));
		apb(1'b1, 8'h10, 32'h200);
		apb(1'b1, 8'h14, 32'h300);
		apb(1'b1, 8'h18, 32'(rlen));
		apb(1'b1, 8'h00, {30'h0, asc, 1'b1});
		rd_v = 32'h0;
		for (int i = 0; i < 300 && rd_v[1] !== 1'b1; i++) rd(8'h04, 33'h0, 32'h0);
		rd(8'h04, 33'h2, 32'h3);
	endtask : run

	task automatic chk_res(input logic [7:0] r[$]);
		foreach (r[i]) cmp_byte(768 + i, r[i]);
	endtask : chk_res

	// ==========================================================
	// scenarios
	initial begin
		logic pos;
		repeat (2) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(posedge clk_sys);
		rd(8'h1c, 33'h0);
		rd(8'h24, 33'h0);
		rd(8'h40, 33'h1_0000_0000);
		apb(1'b1, 8'h1c, 32'hffff_ffff);
		rd(8'h1c, 33'h0);
		$display("registers done");
		run(1'b1, {8'h2a, 8'he0, 8'he0, 8'he0, 8'h43}, {8'h01, 8'h2d}, 4);
		rd(8'h1c, 33'h40_0000);
		rd(8'h20, 33'h300);
		chk_res({8'h2a, 8'h31, 8'h32, 8'h43, 8'hee});
		$display("negative field done");
		run(1'b0, {8'h5c, 8'h20, 8'h20, 8'h6b, 8'h20, 8'h20, 8'h21, 8'h4b, 8'h20, 8'hc3},
			{8'h00, 8'h36, 8'h2c}, 8);
		rd(8'h1c, 33'h80_0000);
		chk_res({8'h5c, 8'h5c, 8'h5c, 8'hf3, 8'hf6, 8'h4b, 8'hf2, 8'h5c});
		$display("positive field done");
		run(1'b0, {8'h21, 8'h20, 8'h20, 8'h20, 8'h6b, 8'h22}, {8'h05, 8'h0c}, 8);
		rd(8'h1c, 33'h20_0000);
		chk_res({8'hf0, 8'hf5, 8'hf0, 8'h40, 8'h40, 8'hee});
		$display("separator done");
		run(1'b0, {8'h5c, 8'h20, 8'h22, 8'h23, 8'h20, 8'h20}, {8'h1c, 8'h00, 8'h5d}, 2);
		rd(8'h1c, 33'h20_0000);
		chk_res({8'hf1, 8'h5c, 8'hee});
		$display("short result done");
		run(1'b0, {8'h5c, 8'h20, 8'h20}, {8'hc1}, 4);
		rd(8'h1c, 33'h40);
		$display("fault done");
		for (int s = 10; s < 16; s++) begin
			pos = s != 11 && s != 13;
			run(1'b0, {8'h5c, 8'h20, 8'h4b}, {8'h70 | 8'(s)}, 2);
			rd(8'h1c, pos ? 33'h80_0000 : 33'h40_0000);
			chk_res({8'hf7, pos ? 8'h5c : 8'h4b});
		end
		rd(8'h20, 33'h2ff);
		rd(8'h24, 33'h0);
		$display("sign codes done");
		complete_run();
	end

	initial begin
		repeat (50000) @(posedge clk_sys);
		n_errors++;
		$display("ERROR watchdog expected done seen hang");
		complete_run();
	end
endmodule : decimal_edit_mark_unit_tb

`default_nettype wire

// *** tb/edit_mark_mem.sv ***
`timescale 1ns/1ns
`default_nettype none

module edit_mark_mem (
	input  wire logic                    clk_sys,
	input  wire logic                    stall,
	input  wire edit_mark_pkg::mem_req_s mem_req,
	output var  edit_mark_pkg::mem_rsp_s mem_rsp
);
	// ==========================================================
	// byte store, a 4 kbyte window of the field space
	logic [7:0] mem [0:4095];
	logic [7:0] junk_r = 8'ha5;

	always_comb begin
		mem_rsp.ready = mem_req.valid && !stall;
		// an unanswered read shows changing junk, never a stale byte
		mem_rsp.rdata = (mem_rsp.ready && !mem_req.we) ? mem[mem_req.addr[11:0]] : junk_r;
	end

	always @(posedge clk_sys) begin
		junk_r <= junk_r + 8'h3b;
		if (mem_rsp.ready && mem_req.we)
			mem[mem_req.addr[11:0]] <= mem_req.wdata;
	end
endmodule : edit_mark_mem

`default_nettype wire
